// *** acs_seq.v ***
// Converter output sync, data ready and calibration sequencer
//
// Notes on behaviour
// - Serial clock starts within 2.5 periods
// - Parallel read raises ready flag one period later
// - Sync low forces ready flag high quickly
// - Sync pulse drops valid output within 40 ns
// - Valid returns 8192 periods after sync low
// - First ready by 8192 plus 64 periods
// - Calibration starts within 64 periods of request
// - Unipolar calibration: 3x8192 plus 2x512 periods
// - Bipolar calibration: 4x8192 plus 3x512 periods
// - First result 64 periods after calibration
// - Frame sync sampled on master clock fall
//
// Local design decisions: the address-and-strobe port and the register addresses.
`default_nettype none
`include "acs_defines.vh"

module acs_seq
#(
   parameter [15:0] SETTLE_PERIODS = `ACS_SETTLE_PERIODS,
   parameter [15:0] CAL_BLOCK_PERIODS = `ACS_CAL_BLOCK_PERIODS,
   parameter [15:0] CAL_STEP_PERIODS = `ACS_CAL_STEP_PERIODS
)
(
   input wire clk_i,
   input wire nrst_i,
   input wire master_clock_in_i,
   input wire frame_sync_in_i,
   input wire sync_reset_n_i,
   input wire cal_request_i,
   input wire read_strobe_n_i,
   input wire input_range_select_i,
   input wire [15:0] filter_data_i,
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   output reg result_ready_n_o,
   output reg result_valid_o,
   output reg [15:0] par_data_o,
   output reg cal_busy_o,
   output reg irq_o,
   output wire serial_clock_out_o,
   output wire frame_sync_out_o,
   output wire serial_data_out_o
);

localparam [1:0] ST_SETTLE = `ACS_ST_SETTLE;
localparam [1:0] ST_RUN = `ACS_ST_RUN;
localparam [1:0] ST_CAL = `ACS_ST_CAL;
// Wide constants, cut to size by part-select
localparam [31:0] CONV_LAST_W = `ACS_CONV_PERIODS - 1;
localparam [31:0] READY_RISE_W =
   `ACS_CONV_PERIODS - 1 - `ACS_READY_HIGH_PERIODS;
localparam [31:0] CAL_UNI_W = 3 * CAL_BLOCK_PERIODS + 2 * CAL_STEP_PERIODS;
localparam [31:0] CAL_BI_W = 4 * CAL_BLOCK_PERIODS + 3 * CAL_STEP_PERIODS;
localparam [5:0] CONV_LAST = CONV_LAST_W[5:0];
localparam [5:0] READY_RISE = READY_RISE_W[5:0];

// Bit positions in the synchroniser vector
localparam MCK = 0;
localparam FRM = 1;
localparam SYN = 2;
localparam CAL = 3;
localparam RDN = 4;
localparam RNG = 5;

// Accept a bit once second and third stages agree
function [5:0] agree;
   input [5:0] a;
   input [5:0] b;
   input [5:0] held;
   begin
      agree = (~(a ^ b) & b) | ((a ^ b) & held);
   end
endfunction

// Calibration length for the selected input range
function [15:0] cal_len;
   input bipolar;
   begin
      if (bipolar)
         cal_len = CAL_BI_W[15:0];
      else
         cal_len = CAL_UNI_W[15:0];
   end
endfunction

reg [5:0] sync1_reg;
reg [5:0] sync2_reg;
reg [5:0] sync3_reg;
reg [5:0] clean_reg;
wire [5:0] clean;
wire mclk_rise;
wire mclk_fall;
wire sync_fall;
wire cal_rise;
wire rd_fall;
wire frame_low;

reg [1:0] state_reg;
reg [15:0] cnt_reg;
reg [15:0] cal_len_reg;
reg [5:0] phase_reg;
reg cal_pend_reg;
reg rd_pend_reg;
reg frame_prev_reg;
reg frame_start_reg;
reg [15:0] result_reg;
reg [15:0] ctrl_reg;
reg [2:0] int_stat_reg;
reg [2:0] int_mask_reg;
reg [2:0] events;
reg [2:0] int_stat_next;
reg [15:0] rdata_next;

// Three-stage synchroniser for the six control inputs; filter data and register port bypass it
always @(posedge clk_i or negedge nrst_i)
begin
   if (!nrst_i)
   begin
      sync1_reg <= 6'h16; // Idle levels: frame, sync and strobe high
      sync2_reg <= 6'h16;
      sync3_reg <= 6'h16;
      clean_reg <= 6'h16;
   end
   else
   begin
      sync1_reg <= {input_range_select_i, read_strobe_n_i, cal_request_i,
                    sync_reset_n_i, frame_sync_in_i, master_clock_in_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      clean_reg <= clean;
   end
end

assign clean = agree(sync2_reg, sync3_reg, clean_reg);
assign mclk_rise = clean[MCK] & ~clean_reg[MCK];
assign mclk_fall = ~clean[MCK] & clean_reg[MCK];
assign sync_fall = ~clean[SYN] & clean_reg[SYN];
assign cal_rise = clean[CAL] & ~clean_reg[CAL];
assign rd_fall = ~clean[RDN] & clean_reg[RDN];
assign frame_low = ~clean[FRM];

// Frame sync sampled on the master clock falling edge
always @(posedge clk_i or negedge nrst_i)
begin
   if (!nrst_i)
   begin
      frame_prev_reg <= 1'b1;
      frame_start_reg <= 1'b0;
   end
   else
   begin
      frame_start_reg <= 1'b0;
      if (mclk_fall)
      begin
         frame_prev_reg <= frame_low;
         frame_start_reg <= frame_low & ~frame_prev_reg;
      end
   end
end

// Event pulses for the interrupt status register
always @*
begin
   events = 3'h0;
   if (mclk_rise && state_reg == ST_RUN && phase_reg == CONV_LAST &&
       ctrl_reg[`ACS_CTRL_RUN_BIT] && clean[SYN])
      events[`ACS_INT_WORD] = 1'b1;
   if (mclk_rise && state_reg == ST_CAL &&
       cnt_reg == cal_len_reg - 16'h0001 && clean[SYN])
      events[`ACS_INT_CAL] = 1'b1;
   if (mclk_rise && state_reg == ST_SETTLE &&
       cnt_reg == SETTLE_PERIODS - 16'h0001 && clean[SYN])
      events[`ACS_INT_SETTLE] = 1'b1;
end

// Main sequencer: settle, run, calibrate
always @(posedge clk_i or negedge nrst_i)
begin
   if (!nrst_i)
   begin
      state_reg <= ST_SETTLE;
      cnt_reg <= 16'h0000;
      cal_len_reg <= 16'h0000;
      phase_reg <= 6'h00;
      cal_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      result_reg <= 16'h0000;
      result_ready_n_o <= 1'b1;
      result_valid_o <= 1'b0;
      par_data_o <= 16'h0000;
      cal_busy_o <= 1'b0;
   end
   else if (!clean[SYN])
   begin
      // Sync held low: flags forced at once, settle count restarts
      result_ready_n_o <= 1'b1;
      result_valid_o <= 1'b0;
      state_reg <= ST_SETTLE;
      phase_reg <= 6'h00;
      rd_pend_reg <= 1'b0;
      cal_busy_o <= 1'b0;
      cal_pend_reg <= 1'b0;
      if (sync_fall)
         cnt_reg <= 16'h0000;
      else if (mclk_rise)
         cnt_reg <= cnt_reg + 16'h0001;
   end
   else
   begin
      if (cal_rise)
         cal_pend_reg <= 1'b1;
      if (rd_fall)
         rd_pend_reg <= 1'b1;
      if (mclk_rise)
      begin
         // Read returns the ready flag high one period on
         if (rd_pend_reg || rd_fall)
         begin
            result_ready_n_o <= 1'b1;
            rd_pend_reg <= 1'b0;
         end
         case (state_reg)
            ST_SETTLE:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg == SETTLE_PERIODS - 16'h0001)
               begin
                  result_valid_o <= 1'b1;
                  state_reg <= ST_RUN;
                  phase_reg <= 6'h00;
               end
            end
            ST_RUN:
            begin
               phase_reg <= phase_reg + 6'h01;
               // Unread word drops its flag before the next one
               if (phase_reg == READY_RISE)
                  result_ready_n_o <= 1'b1;
               if (phase_reg == CONV_LAST)
               begin
                  phase_reg <= 6'h00;
                  if (ctrl_reg[`ACS_CTRL_RUN_BIT])
                  begin
                     result_reg <= filter_data_i;
                     par_data_o <= filter_data_i;
                     result_ready_n_o <= 1'b0;
                  end
                  // Pending request begins on the word boundary
                  if (cal_pend_reg || cal_rise)
                  begin
                     state_reg <= ST_CAL;
                     cal_pend_reg <= 1'b0;
                     cnt_reg <= 16'h0000;
                     cal_len_reg <= cal_len(clean[RNG]);
                     cal_busy_o <= 1'b1;
                     result_valid_o <= 1'b0;
                     result_ready_n_o <= 1'b1;
                  end
               end
            end
            ST_CAL:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg == cal_len_reg - 16'h0001)
               begin
                  state_reg <= ST_RUN;
                  phase_reg <= 6'h00;
                  cal_busy_o <= 1'b0;
                  result_valid_o <= 1'b1;
               end
            end
            default:
            begin
               state_reg <= ST_SETTLE;
               cnt_reg <= 16'h0000;
            end
         endcase
      end
   end
end

// Sticky status, set wins over write-one-to-clear
always @*
begin
   int_stat_next = int_stat_reg | events;
   if (reg_wr_i && reg_addr_i == `ACS_REG_INT_STAT)
      int_stat_next = (int_stat_reg & ~reg_wdata_i[2:0]) | events;
end

// Read data mux, zero for unmapped addresses
always @*
begin
   rdata_next = 16'h0000;
   case (reg_addr_i)
      `ACS_REG_CTRL: rdata_next = ctrl_reg;
      `ACS_REG_STATUS: rdata_next = {9'h000, cal_pend_reg, cal_busy_o,
         result_valid_o, result_ready_n_o, 1'b0, state_reg};
      `ACS_REG_RESULT: rdata_next = result_reg;
      `ACS_REG_INT_STAT: rdata_next = {13'h0000, int_stat_reg};
      `ACS_REG_INT_MASK: rdata_next = {13'h0000, int_mask_reg};
      default: rdata_next = 16'h0000;
   endcase
end

// Register writes, read data and interrupt line
always @(posedge clk_i or negedge nrst_i)
begin
   if (!nrst_i)
   begin
      ctrl_reg <= `ACS_CTRL_RESET;
      int_stat_reg <= 3'h0;
      int_mask_reg <= `ACS_INT_MASK_RESET;
      reg_rdata_o <= 16'h0000;
      irq_o <= 1'b0;
   end
   else
   begin
      int_stat_reg <= int_stat_next;
      irq_o <= |(int_stat_next & int_mask_reg);
      reg_rdata_o <= reg_rd_i ? rdata_next : 16'h0000;
      if (reg_wr_i && reg_addr_i == `ACS_REG_CTRL)
         ctrl_reg <= {15'h0000, reg_wdata_i[`ACS_CTRL_RUN_BIT]};
      if (reg_wr_i && reg_addr_i == `ACS_REG_INT_MASK)
      begin
         int_mask_reg <= reg_wdata_i[2:0];
         irq_o <= |(int_stat_next & reg_wdata_i[2:0]);
      end
   end
end

// Serial output port
acs_serial_tx u_tx
(
   .clk_i(clk_i),
   .nrst_i(nrst_i),
   .mclk_rise_i(mclk_rise),
   .start_i(frame_start_reg),
   .word_i(result_reg),
   .serial_clock_out_o(serial_clock_out_o),
   .frame_sync_out_o(frame_sync_out_o),
   .serial_data_out_o(serial_data_out_o)
);

endmodule
`default_nettype wire

// *** acs_defines.vh ***
// Constants for the converter output sync and calibration sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// Register indices on the plain register port
`define ACS_ADDR_W 4
`define ACS_DATA_W 16
`define ACS_REG_CTRL 4'h0
`define ACS_REG_STATUS 4'h1
`define ACS_REG_RESULT 4'h2
`define ACS_REG_INT_STAT 4'h3
`define ACS_REG_INT_MASK 4'h4

// Control fields and reset values
`define ACS_CTRL_RUN_BIT 0
`define ACS_CTRL_RESET 16'h0001
`define ACS_INT_MASK_RESET 3'h0

// Interrupt status bit positions
`define ACS_INT_WORD 0
`define ACS_INT_CAL 1
`define ACS_INT_SETTLE 2

// Timing in master clock periods, and serial word length in bits
`define ACS_CONV_PERIODS 64
`define ACS_READY_HIGH_PERIODS 2
`define ACS_SETTLE_PERIODS 8192
`define ACS_CAL_BLOCK_PERIODS 8192
`define ACS_CAL_STEP_PERIODS 512
`define ACS_WORD_BITS 16

// Sequencer states
`define ACS_ST_SETTLE 2'h0
`define ACS_ST_RUN 2'h1
`define ACS_ST_CAL 2'h2

`endif

// *** acs_serial_tx.v ***
// Serial output shifter: bit clock, frame pulse and data out
`default_nettype none
`include "acs_defines.vh"

module acs_serial_tx
(
   input wire clk_i,
   input wire nrst_i,
   input wire mclk_rise_i,
   input wire start_i,
   input wire [15:0] word_i,
   output reg serial_clock_out_o,
   output reg frame_sync_out_o,
   output reg serial_data_out_o
);

reg [15:0] shift_reg;
reg [4:0] bits_reg;
reg active_reg;
// Index of the last bit, cut from a wide constant
localparam [31:0] LAST_BIT_W = `ACS_WORD_BITS - 1;

// Load on frame start, toggle bit clock on each master clock rise
always @(posedge clk_i or negedge nrst_i)
begin
   if (!nrst_i)
   begin
      shift_reg <= 16'h0000;
      bits_reg <= 5'h00;
      active_reg <= 1'b0;
      serial_clock_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
      serial_data_out_o <= 1'b0;
   end
   else if (start_i)
   begin
      shift_reg <= word_i;
      bits_reg <= 5'h00;
      active_reg <= 1'b1;
      serial_clock_out_o <= 1'b0;
      frame_sync_out_o <= 1'b1; // Marks the first bit
      serial_data_out_o <= word_i[15];
   end
   else if (active_reg && mclk_rise_i)
   begin
      serial_clock_out_o <= ~serial_clock_out_o;
      // Falling bit clock advances to the next bit
      if (serial_clock_out_o)
      begin
         frame_sync_out_o <= 1'b0;
         if (bits_reg == LAST_BIT_W[4:0])
         begin
            active_reg <= 1'b0;
            serial_data_out_o <= 1'b0;
         end
         else
         begin
            bits_reg <= bits_reg + 5'h01;
            shift_reg <= {shift_reg[14:0], 1'b0};
            serial_data_out_o <= shift_reg[14];
         end
      end
   end
end

endmodule
`default_nettype wire

// *** acs_seq_assertions.sv ***
// Checker for sequencer flag, calibration and serial timing
`default_nettype none
module acs_seq_checker
#(
   parameter [15:0] SETTLE_PERIODS = 16'h2000,
   parameter [15:0] CAL_BLOCK_PERIODS = 16'h2000,
   parameter [15:0] CAL_STEP_PERIODS = 16'h0200
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic sync_reset_n_i,
   input wire logic read_strobe_n_i,
   input wire logic frame_sync_in_i,
   input wire logic input_range_select_i,
   input wire logic result_ready_n_o,
   input wire logic result_valid_o,
   input wire logic cal_busy_o,
   input wire logic serial_clock_out_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Limits in clk cycles; a master period is under 16 of them
   localparam int SET_MAX = SETTLE_PERIODS * 16 + 40;
   localparam int GAP_MAX = 64 * 16 + 40;
   localparam int UNI_MAX =
      (3 * CAL_BLOCK_PERIODS + 2 * CAL_STEP_PERIODS) * 16 + 40;
   localparam int BI_MAX =
      (4 * CAL_BLOCK_PERIODS + 3 * CAL_STEP_PERIODS) * 16 + 40;
   int set_cnt;
   int gap_cnt;
   int cal_cnt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // Cycles spent unsettled, waiting for a word, and calibrating
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         set_cnt <= 0;
         gap_cnt <= 0;
         cal_cnt <= 0;
      end
      else
      begin
         set_cnt <= (result_valid_o || cal_busy_o) ? 0 : set_cnt + 1;
         gap_cnt <= (result_valid_o && result_ready_n_o) ? gap_cnt + 1 : 0;
         cal_cnt <= cal_busy_o ? cal_cnt + 1 : 0;
      end
   end
   property p_sync_ready;
      $fell(sync_reset_n_i) |-> ##[1:6] result_ready_n_o;
   endproperty
   a_sync_ready: assert property (p_sync_ready)
      else $error("ready not forced high");
   property p_sync_valid;
      $fell(sync_reset_n_i) |-> ##[1:5] !result_valid_o;
   endproperty
   a_sync_valid: assert property (p_sync_valid)
      else $error("valid not dropped");
   property p_read_ready;
      $fell(read_strobe_n_i) && sync_reset_n_i |-> ##[1:24] result_ready_n_o;
   endproperty
   a_read_ready: assert property (p_read_ready)
      else $error("ready not raised by read");
   property p_settle;
      set_cnt < SET_MAX;
   endproperty
   a_settle: assert property (p_settle)
      else $error("valid late after settle");
   property p_word_gap;
      gap_cnt < GAP_MAX;
   endproperty
   a_word_gap: assert property (p_word_gap)
      else $error("word late");
   property p_ready_hold;
      $rose(result_ready_n_o) |-> result_ready_n_o [*8];
   endproperty
   a_ready_hold: assert property (p_ready_hold)
      else $error("ready high too short");
   property p_sclk_start;
      $fell(frame_sync_in_i) |-> ##[1:45] serial_clock_out_o;
   endproperty
   a_sclk_start: assert property (p_sclk_start)
      else $error("serial clock late");
   property p_cal_len;
      cal_busy_o |-> cal_cnt < (input_range_select_i ? BI_MAX : UNI_MAX);
   endproperty
   a_cal_len: assert property (p_cal_len)
      else $error("calibration too long");
   c_cal: cover property ($rose(cal_busy_o));
   c_frame: cover property ($rose(serial_clock_out_o));
   c_read: cover property ($fell(read_strobe_n_i));
endmodule
bind acs_seq acs_seq_checker #(.SETTLE_PERIODS(SETTLE_PERIODS),
   .CAL_BLOCK_PERIODS(CAL_BLOCK_PERIODS),
   .CAL_STEP_PERIODS(CAL_STEP_PERIODS)) u_chk (.clk_i, .nrst_i,
   .sync_reset_n_i, .read_strobe_n_i, .frame_sync_in_i,
   .input_range_select_i, .result_ready_n_o, .result_valid_o,
   .cal_busy_o, .serial_clock_out_o);
`default_nettype wire

// *** acs_host_model.sv ***
// Host model: parallel reader and serial frame receiver
`default_nettype none
module acs_host_model
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic rd_en_i,
   input wire logic ready_n_i,
   input wire logic [15:0] data_i,
   input wire logic sclk_i,
   input wire logic frame_i,
   input wire logic bit_i,
   output logic strobe_n_o,
   output logic [15:0] rd_word_o,
   output logic [15:0] rx_word_o,
   output logic rx_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_q;
   int hold;
   int nbit;
   // Strobe wider than a master period; bits taken on serial clock rise
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         strobe_n_o <= 1'h1;
         hold <= 0;
         nbit <= 0;
         sclk_q <= 1'h0;
         rx_word_o <= 16'h0000;
         rd_word_o <= 16'h0000;
         rx_done_o <= 1'h0;
      end
      else
      begin
         sclk_q <= sclk_i;
         rx_done_o <= (nbit == 16);
         if (hold == 1)
         begin
            strobe_n_o <= 1'h1;
            rd_word_o <= data_i;
         end
         if (hold != 0)
            hold <= hold - 1;
         else if (rd_en_i && !ready_n_i)
         begin
            strobe_n_o <= 1'h0;
            hold <= 32;
         end
         if (sclk_i && !sclk_q)
         begin
            rx_word_o <= {rx_word_o[14:0], bit_i};
            nbit <= frame_i ? 1 : nbit + 1;
         end
      end
   end
endmodule
`default_nettype wire

// *** acs_tb.sv ***
// Testbench for the converter sequencer
`default_nettype none
`include "acs_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0, nrst_i = 1'h0, master_clock_in_i = 1'h0, rd_en = 1'h0;
   logic frame_sync_in_i = 1'h1, sync_reset_n_i = 1'h1, cal_request_i = 1'h0;
   logic input_range_select_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000, filter_data_i = 16'h9c35, q;
   logic [15:0] reg_rdata_o, par_data_o, rd_word, rx_word;
   logic read_strobe_n_i, result_ready_n_o, result_valid_o, cal_busy_o, irq_o;
   logic serial_clock_out_o, frame_sync_out_o, serial_data_out_o, rx_done;
   int n_errors = 0, tests_run = 0, n;
   // System clock and a phase unrelated master clock
   always #4 clk_i = ~clk_i;
   always #62.5 master_clock_in_i = ~master_clock_in_i;
   acs_seq #(.SETTLE_PERIODS(16'h0010), .CAL_BLOCK_PERIODS(16'h0010),
      .CAL_STEP_PERIODS(16'h0004)) dut (.clk_i, .nrst_i, .master_clock_in_i,
      .frame_sync_in_i, .sync_reset_n_i, .cal_request_i, .read_strobe_n_i,
      .input_range_select_i, .filter_data_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .result_ready_n_o, .result_valid_o,
      .par_data_o, .cal_busy_o, .irq_o, .serial_clock_out_o,
      .frame_sync_out_o, .serial_data_out_o);
   acs_host_model host (.clk_i, .nrst_i, .rd_en_i(rd_en),
      .ready_n_i(result_ready_n_o), .data_i(par_data_o),
      .sclk_i(serial_clock_out_o), .frame_i(frame_sync_out_o),
      .bit_i(serial_data_out_o), .strobe_n_o(read_strobe_n_i),
      .rd_word_o(rd_word), .rx_word_o(rx_word), .rx_done_o(rx_done));
   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return result_valid_o;
         1: return result_ready_n_o;
         2: return cal_busy_o;
         3: return serial_clock_out_o;
         default: return rx_done;
      endcase
   endfunction
   // Bounded wait for a level; cycles taken left in n
   task automatic wt(input int s, input logic lvl, input int lim);
      n = 0;
      while (sig(s) !== lvl)
      begin
         @(posedge clk_i);
         #1;
         n++;
         if (n > lim)
         begin
            n_errors++;
            close_out;
         end
      end
   endtask
   task automatic reg_io(input logic wr, input logic [3:0] a,
      input logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      @(posedge clk_i);
      reg_wr_i <= 1'h0;
      reg_rd_i <= 1'h0;
      #1 q = reg_rdata_o;
   endtask
   // Settle after reset, first word, one parallel read
   task automatic t_start;
      wt(0, 1'h1, 16 * 16 + 20);
      wt(1, 1'h0, 64 * 16 + 40);
      chk(par_data_o, 16'h9c35);
      @(posedge clk_i);
      rd_en <= 1'h1;
      wt(1, 1'h1, 30);
      cyc(40);
      chk(rd_word, 16'h9c35);
   endtask
   // Short sync pulse in mid run, while an unread word is flagged
   task automatic t_sync;
      rd_en <= 1'h0;
      wt(1, 1'h0, 64 * 16 + 40);
      @(posedge clk_i);
      sync_reset_n_i <= 1'h0;
      filter_data_i <= 16'h3ac5;
      cyc(3);
      sync_reset_n_i <= 1'h1;
      cyc(2);
      #1;
      chk(result_ready_n_o, 16'h0001);
      chk(result_valid_o, 16'h0000);
      wt(0, 1'h1, 16 * 16 + 20);
      wt(1, 1'h0, 64 * 16 + 40);
      chk(par_data_o, 16'h3ac5);
   endtask
   // One serial frame
   task automatic t_frame;
      @(posedge clk_i);
      frame_sync_in_i <= 1'h0;
      wt(3, 1'h1, 45);
      cyc(40);
      frame_sync_in_i <= 1'h1;
      wt(4, 1'h1, 34 * 16);
      chk(rx_word, 16'h3ac5);
   endtask
   // Calibration in one input range
   task automatic t_cal(input logic sel);
      @(posedge clk_i);
      input_range_select_i <= sel;
      cyc(40);
      cal_request_i <= 1'h1;
      cyc(24);
      cal_request_i <= 1'h0;
      wt(2, 1'h1, 64 * 16);
      wt(2, 1'h0, (sel ? 76 : 56) * 16 + 20);
      chk(n >= (sel ? 75 : 55) * 15, 16'h0001);
      wt(0, 1'h1, 20);
      wt(1, 1'h0, 64 * 16 + 40);
   endtask
   // Interrupt mask and clear, unmapped read
   task automatic t_regs;
      chk(irq_o, 16'h0000);
      reg_io(1'h0, `ACS_REG_INT_STAT, 16'h0000);
      chk(q & 16'h0007, 16'h0007);
      reg_io(1'h1, `ACS_REG_INT_MASK, 16'h0002);
      cyc(1);
      #1;
      chk(irq_o, 16'h0001);
      reg_io(1'h1, `ACS_REG_INT_STAT, 16'h0002);
      cyc(1);
      #1;
      chk(irq_o, 16'h0000);
      reg_io(1'h0, `ACS_REG_INT_STAT, 16'h0000);
      chk(q & 16'h0002, 16'h0000);
      reg_io(1'h0, 4'hf, 16'h0000);
      chk(q, 16'h0000);
      reg_io(1'h0, `ACS_REG_CTRL, 16'h0000);
      chk(q, 16'h0001);
      reg_io(1'h0, `ACS_REG_STATUS, 16'h0000);
      chk(q & 16'h0073, 16'h0011);
   endtask
   // Main sequence
   initial
   begin
      cyc(2);
      nrst_i <= 1'h1;
      t_start;
      t_sync;
      t_frame;
      t_cal(1'h0);
      t_cal(1'h1);
      t_regs;
      close_out;
   end
endmodule
`default_nettype wire
